// ==== verilog/scu_defs.svh ====
/*
  Constants of the serial controller in asynchronous line mode.
  Included by the line controller and its buffer; holds definitions only.
*/
`ifndef SCU_DEFS_SVH
`define SCU_DEFS_SVH

`define SCU_MODE_W          2
`define SCU_MODE_LINE       2'h1
`define SCU_PERIOD_W        16
`define SCU_PERIOD_MIN      16'h0008
`define SCU_REF_MHZ         24
`define SCU_SYS_MHZ         20
`define SCU_ACC_W           22
`define SCU_FIFO_DEPTH      4
`define SCU_FIFO_CNT_W      3
`define SCU_RTS_MAX_FILL    3'h2
`define SCU_RX_ENTRY_W      10
`define SCU_RX_PAR_BIT      8
`define SCU_RX_FRM_BIT      9
`define SCU_BITCNT_W        3
`define SCU_OFFSET_W        16
`define SCU_EVT_W           10
`define SCU_EVT_TX_IDLE     0
`define SCU_EVT_TX_SPACE    1
`define SCU_EVT_RX_VALID    2
`define SCU_EVT_TXDMA_A     3
`define SCU_EVT_TXDMA_B     4
`define SCU_EVT_RXDMA_A     5
`define SCU_EVT_RXDMA_B     6
`define SCU_EVT_PARITY      7
`define SCU_EVT_FRAMING     8
`define SCU_EVT_OVERRUN     9

`endif

// ==== verilog/scu_pkg.sv ====
/*
  Types of the serial controller in asynchronous line mode.
  Used by the line controller through scoped names only.
*/
package scu_pkg;
  typedef enum logic [2:0] {
    LINE_IDLE,
    LINE_START,
    LINE_DATA,
    LINE_PARITY,
    LINE_STOP
  } scu_line_state_type;
endpackage

// ==== verilog/scu_stream_if.sv ====
/*
  Valid/ready stream carrier between the line controller and its buffers.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/10ps
interface scu_stream_if #(
  parameter int WIDTH = 8
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

// ==== verilog/scu_fifo.sv ====
/*
  Parameterised first-in first-out buffer with valid/ready on both sides.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
`include "scu_defs.svh"
module scu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic                      clk_sys,
  input  wire logic                      resetn,
  scu_stream_if.sink                     fill,
  scu_stream_if.source                   drain,
  output logic [$clog2(DEPTH+1)-1:0]     count,
  input  wire logic                      flush
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_q;
  logic [PW-1:0]    rdPtr_q;
  logic [CW-1:0]    count_q;

  wire doPush = fill.valid & fill.ready;
  wire doPop  = drain.valid & drain.ready;

  assign fill.ready  = (count_q != CW'(DEPTH));
  assign drain.valid = (count_q != '0);
  assign drain.data  = mem[rdPtr_q];
  assign count       = count_q;

  always_ff @(posedge clk_sys) begin
    if (doPush) begin
      mem[wrPtr_q] <= fill.data;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else if (flush) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (doPush) begin
        wrPtr_q <= (wrPtr_q == PW'(DEPTH - 1)) ? '0 : wrPtr_q + PW'(1);
      end
      if (doPop) begin
        rdPtr_q <= (rdPtr_q == PW'(DEPTH - 1)) ? '0 : rdPtr_q + PW'(1);
      end
      count_q <= count_q + CW'(doPush) - CW'(doPop);
    end
  end
endmodule

// ==== verilog/scu_line_ctrl.sv ====
/*
  Serial controller, asynchronous line mode: baud generator, framer,
  deframer, transmit and receive buffers, flow control, receive error
  offsets for the two receive DMA buffers, and interrupt events.
  Assumes one 20 MHz clock; the line pins come from outside and are
  synchronised here; DMA and software sit on the same clock.
*/
`timescale 1ns/10ps
`include "scu_defs.svh"
module scu_line_ctrl (
  input  wire logic                     clk_sys,
  input  wire logic                     resetn,
  input  wire logic [`SCU_MODE_W-1:0]   serialProtocolSelect,
  input  wire logic [`SCU_PERIOD_W-1:0] baudPeriodInteger,
  input  wire logic                     baudPeriodHalfStep,
  input  wire logic                     eightDataBits,
  input  wire logic                     twoStopBits,
  input  wire logic                     parityEnable,
  input  wire logic                     oddParitySelect,
  input  wire logic                     flowControlEnable,
  input  wire logic                     autoRequestToSend,
  input  wire logic                     softRequestToSend,
  input  wire logic                     fourWirePinMap,
  input  wire logic                     txWrite,
  input  wire logic [7:0]               txWriteData,
  input  wire logic                     rxRead,
  input  wire logic                     dmaRxRead,
  input  wire logic [1:0]               txBufferActiveAB,
  input  wire logic [1:0]               rxBufferActiveAB,
  input  wire logic [1:0]               rxBufferLoad,
  input  wire logic [1:0]               dmaChannelReset,
  input  wire logic                     rxOverrunClear,
  input  wire logic [`SCU_EVT_W-1:0]    serialInterruptMask,
  input  wire logic                     topInterruptEnable,
  input  wire logic                     rxdPin,
  input  wire logic                     clearToSendN,
  output logic                          txdPin,
  output logic                          requestToSendN,
  output logic                          txAllSent,
  output logic                          txFifoHasSpace,
  output logic                          rxFifoNonempty,
  output logic [7:0]                    rxReadData,
  output logic                          rxParityError,
  output logic                          rxFramingError,
  output logic                          rxOverrun,
  output logic [1:0]                    rxErrorValidAB,
  output logic [`SCU_OFFSET_W-1:0]      rxErrorOffsetA,
  output logic [`SCU_OFFSET_W-1:0]      rxErrorOffsetB,
  output logic                          serialIrq
);
  localparam logic [`SCU_ACC_W-1:0] REF_STEP = `SCU_ACC_W'(`SCU_REF_MHZ);
  localparam logic [`SCU_ACC_W-1:0] SYS_STEP = `SCU_ACC_W'(`SCU_SYS_MHZ);

  scu_stream_if #(.WIDTH(8))                 txIn ();
  scu_stream_if #(.WIDTH(8))                 txOut ();
  scu_stream_if #(.WIDTH(`SCU_RX_ENTRY_W))   rxIn ();
  scu_stream_if #(.WIDTH(`SCU_RX_ENTRY_W))   rxOut ();
  logic [`SCU_FIFO_CNT_W-1:0] txCount;
  logic [`SCU_FIFO_CNT_W-1:0] rxCount;

  // Pin synchronisers
  logic [1:0] rxdSync_q;
  logic [1:0] ctsSync_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rxdSync_q <= 2'h3;
      ctsSync_q <= 2'h3;
    end else begin
      rxdSync_q <= {rxdSync_q[0], rxdPin};
      ctsSync_q <= {ctsSync_q[0], clearToSendN};
    end
  end
  wire rxdLine = rxdSync_q[1];
  wire ctsOn   = ~ctsSync_q[1];

  wire lineMode = (serialProtocolSelect == `SCU_MODE_LINE);
  wire flush    = ~lineMode;

  // Fractional divider: one bit is (2N+F) cycles of 24 MHz; step 24 per 20 MHz clock
  wire [`SCU_ACC_W-1:0] bitLimit = (`SCU_ACC_W'(baudPeriodInteger) * `SCU_ACC_W'(2)
                                    + `SCU_ACC_W'(baudPeriodHalfStep)) * SYS_STEP;
  wire [`SCU_ACC_W-1:0] halfLimit = bitLimit >> 1;
  wire [`SCU_BITCNT_W-1:0] lastBit = eightDataBits ? 3'h7 : 3'h6;

  // Transmitter
  scu_pkg::scu_line_state_type txState_q;
  logic [`SCU_ACC_W-1:0]    txAcc_q;
  logic [7:0]               txShift_q;
  logic [`SCU_BITCNT_W-1:0] txBit_q;
  logic                     txPar_q;
  logic                     txStop2_q;
  logic                     txd_q;

  wire txTick  = (txAcc_q + REF_STEP) >= bitLimit;
  wire txMayGo = ~flowControlEnable | ctsOn;
  wire txStart = lineMode & (txState_q == scu_pkg::LINE_IDLE) & txOut.valid & txMayGo;
  assign txOut.ready = txStart;
  assign txIn.valid  = txWrite & lineMode;
  assign txIn.data   = txWriteData;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      txAcc_q <= '0;
    end else if (txStart || txState_q == scu_pkg::LINE_IDLE) begin
      txAcc_q <= '0;
    end else begin
      txAcc_q <= txTick ? (txAcc_q + REF_STEP - bitLimit) : (txAcc_q + REF_STEP);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      txState_q <= scu_pkg::LINE_IDLE;
      txShift_q <= '0;
      txBit_q   <= '0;
      txPar_q   <= 1'b0;
      txStop2_q <= 1'b0;
      txd_q     <= 1'b1;
    end else if (flush) begin
      txState_q <= scu_pkg::LINE_IDLE;
      txd_q     <= 1'b1;
    end else begin
      case (txState_q)
        scu_pkg::LINE_IDLE: begin
          txd_q <= 1'b1;
          if (txStart) begin
            txShift_q <= txOut.data;
            txPar_q   <= oddParitySelect;
            txBit_q   <= '0;
            txStop2_q <= twoStopBits;
            txd_q     <= 1'b0;
            txState_q <= scu_pkg::LINE_START;
          end
        end
        scu_pkg::LINE_START, scu_pkg::LINE_DATA: begin
          if (txTick) begin
            if (txState_q == scu_pkg::LINE_START) begin
              txd_q     <= txShift_q[0];
              txPar_q   <= txPar_q ^ txShift_q[0];
              txShift_q <= txShift_q >> 1;
              txState_q <= scu_pkg::LINE_DATA;
            end else if (txBit_q != lastBit) begin
              txd_q     <= txShift_q[0];
              txPar_q   <= txPar_q ^ txShift_q[0];
              txShift_q <= txShift_q >> 1;
              txBit_q   <= txBit_q + 3'h1;
            end else if (parityEnable) begin
              txd_q     <= txPar_q;
              txState_q <= scu_pkg::LINE_PARITY;
            end else begin
              txd_q     <= 1'b1;
              txState_q <= scu_pkg::LINE_STOP;
            end
          end
        end
        scu_pkg::LINE_PARITY: begin
          if (txTick) begin
            txd_q     <= 1'b1;
            txState_q <= scu_pkg::LINE_STOP;
          end
        end
        scu_pkg::LINE_STOP: begin
          if (txTick) begin
            if (txStop2_q) begin
              txStop2_q <= 1'b0;
            end else begin
              txState_q <= scu_pkg::LINE_IDLE;
            end
          end
        end
        default: txState_q <= scu_pkg::LINE_IDLE;
      endcase
    end
  end

  // Receiver: start detect restarts the divider at half a bit to sample mid-bit
  scu_pkg::scu_line_state_type rxState_q;
  logic [`SCU_ACC_W-1:0]    rxAcc_q;
  logic [7:0]               rxShift_q;
  logic [`SCU_BITCNT_W-1:0] rxBit_q;
  logic                     rxPar_q;
  logic                     rxParErr_q;
  logic                     rxPush_q;
  logic                     rxFrm_q;

  wire rxTick  = (rxAcc_q + REF_STEP) >= bitLimit;
  wire rxBegin = lineMode & (rxState_q == scu_pkg::LINE_IDLE) & ~rxdLine;
  wire [7:0] rxAligned = eightDataBits ? rxShift_q : {1'b0, rxShift_q[7:1]};
  assign rxIn.valid = rxPush_q;
  assign rxIn.data  = {rxFrm_q, rxParErr_q, rxAligned};
  wire rxDrop       = rxPush_q & ~rxIn.ready;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rxAcc_q <= '0;
    end else if (rxBegin) begin
      rxAcc_q <= halfLimit;
    end else begin
      rxAcc_q <= rxTick ? (rxAcc_q + REF_STEP - bitLimit) : (rxAcc_q + REF_STEP);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rxState_q  <= scu_pkg::LINE_IDLE;
      rxShift_q  <= '0;
      rxBit_q    <= '0;
      rxPar_q    <= 1'b0;
      rxParErr_q <= 1'b0;
      rxFrm_q    <= 1'b0;
      rxPush_q   <= 1'b0;
    end else if (flush) begin
      rxState_q <= scu_pkg::LINE_IDLE;
      rxPush_q  <= 1'b0;
    end else begin
      rxPush_q <= 1'b0;
      case (rxState_q)
        scu_pkg::LINE_IDLE: begin
          if (rxBegin) begin
            rxState_q <= scu_pkg::LINE_START;
          end
        end
        scu_pkg::LINE_START: begin
          if (rxTick) begin
            rxBit_q    <= '0;
            rxPar_q    <= oddParitySelect;
            rxParErr_q <= 1'b0;
            // Glitch shorter than half a bit is not a start
            rxState_q  <= rxdLine ? scu_pkg::LINE_IDLE : scu_pkg::LINE_DATA;
          end
        end
        scu_pkg::LINE_DATA: begin
          if (rxTick) begin
            rxShift_q <= {rxdLine, rxShift_q[7:1]};
            rxPar_q   <= rxPar_q ^ rxdLine;
            rxBit_q   <= rxBit_q + 3'h1;
            if (rxBit_q == lastBit) begin
              rxState_q <= parityEnable ? scu_pkg::LINE_PARITY : scu_pkg::LINE_STOP;
            end
          end
        end
        scu_pkg::LINE_PARITY: begin
          if (rxTick) begin
            rxParErr_q <= rxPar_q ^ rxdLine;
            rxState_q  <= scu_pkg::LINE_STOP;
          end
        end
        scu_pkg::LINE_STOP: begin
          if (rxTick) begin
            rxFrm_q   <= ~rxdLine;
            rxPush_q  <= 1'b1;
            rxState_q <= scu_pkg::LINE_IDLE;
          end
        end
        default: rxState_q <= scu_pkg::LINE_IDLE;
      endcase
    end
  end

  scu_fifo #(.WIDTH(8), .DEPTH(`SCU_FIFO_DEPTH)) txFifo (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .fill    (txIn),
    .drain   (txOut),
    .count   (txCount),
    .flush   (flush)
  );

  scu_fifo #(.WIDTH(`SCU_RX_ENTRY_W), .DEPTH(`SCU_FIFO_DEPTH)) rxFifo (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .fill    (rxIn),
    .drain   (rxOut),
    .count   (rxCount),
    .flush   (flush)
  );

  wire anyRead = rxRead | dmaRxRead;
  assign rxOut.ready = anyRead;
  wire popHasErr = rxOut.valid & anyRead
                   & (rxOut.data[`SCU_RX_PAR_BIT] | rxOut.data[`SCU_RX_FRM_BIT]);

  wire allSentNow = ~txOut.valid & (txState_q == scu_pkg::LINE_IDLE);
  wire rtsAuto    = rxCount <= `SCU_RTS_MAX_FILL;
  wire rtsOn      = flowControlEnable & fourWirePinMap
                    & (autoRequestToSend ? rtsAuto : softRequestToSend);

  // DMA receive error offsets, one record per buffer
  logic [`SCU_OFFSET_W-1:0] rxOffCnt_q [2];
  logic [`SCU_OFFSET_W-1:0] rxErrOff_q [2];
  logic [1:0]               rxErrVal_q;
  logic                     ovfPend_q;
  logic [1:0]               rxLoaded_q;
  wire                      dmaSelB = ~rxBufferActiveAB[0];
  wire                      ovfMark = ovfPend_q & ~rxOut.valid & (|rxBufferActiveAB);

  genvar b;
  generate
    for (b = 0; b < 2; b++) begin : gBuf
      wire mine    = rxBufferActiveAB[b] & (dmaSelB == 1'(b));
      wire reload  = rxBufferLoad[b] & ~rxBufferActiveAB[b];
      wire errHit  = mine & ((dmaRxRead & popHasErr) | ovfMark);
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          rxOffCnt_q[b] <= '0;
          rxErrOff_q[b] <= '0;
          rxErrVal_q[b] <= 1'b0;
        end else begin
          if (reload) begin
            rxOffCnt_q[b] <= '0;
          end else if (mine & dmaRxRead & rxOut.valid) begin
            rxOffCnt_q[b] <= rxOffCnt_q[b] + `SCU_OFFSET_W'(1);
          end
          if (errHit & ~rxErrVal_q[b]) begin
            rxErrOff_q[b] <= rxOffCnt_q[b];
            rxErrVal_q[b] <= 1'b1;
          end else if (dmaChannelReset[b] | (reload & rxLoaded_q[b])) begin
            rxErrVal_q[b] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Events and status
  logic [1:0]            txActPrev_q;
  logic [`SCU_EVT_W-1:0] evt;
  always_comb begin
    evt = '0;
    evt[`SCU_EVT_TX_IDLE]  = allSentNow & ~txAllSent;
    evt[`SCU_EVT_TX_SPACE] = txIn.ready & ~txFifoHasSpace;
    evt[`SCU_EVT_RX_VALID] = rxOut.valid & ~rxFifoNonempty;
    evt[`SCU_EVT_TXDMA_A]  = txActPrev_q[0] & ~txBufferActiveAB[0];
    evt[`SCU_EVT_TXDMA_B]  = txActPrev_q[1] & ~txBufferActiveAB[1];
    evt[`SCU_EVT_RXDMA_A]  = rxLoaded_q[0] & ~rxBufferActiveAB[0];
    evt[`SCU_EVT_RXDMA_B]  = rxLoaded_q[1] & ~rxBufferActiveAB[1];
    evt[`SCU_EVT_PARITY]   = rxPush_q & rxParErr_q;
    evt[`SCU_EVT_FRAMING]  = rxPush_q & rxFrm_q;
    evt[`SCU_EVT_OVERRUN]  = rxDrop;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      txActPrev_q    <= '0;
      rxLoaded_q     <= '0;
      ovfPend_q      <= 1'b0;
      txdPin         <= 1'b1;
      requestToSendN <= 1'b1;
      txAllSent      <= 1'b1;
      txFifoHasSpace <= 1'b1;
      rxFifoNonempty <= 1'b0;
      rxReadData     <= '0;
      rxParityError  <= 1'b0;
      rxFramingError <= 1'b0;
      rxOverrun      <= 1'b0;
      serialIrq      <= 1'b0;
    end else begin
      txActPrev_q    <= txBufferActiveAB;
      rxLoaded_q     <= rxBufferActiveAB;
      // Only an overrun during DMA operation is marked for DMA
      ovfPend_q      <= (rxDrop & (|rxBufferActiveAB)) | (ovfPend_q & ~ovfMark);
      txdPin         <= lineMode ? txd_q : 1'b1;
      requestToSendN <= ~(lineMode & rtsOn);
      txAllSent      <= allSentNow;
      txFifoHasSpace <= txIn.ready;
      rxFifoNonempty <= rxOut.valid;
      rxReadData     <= rxOut.data[7:0];
      rxParityError  <= rxOut.valid & rxOut.data[`SCU_RX_PAR_BIT];
      rxFramingError <= rxOut.valid & rxOut.data[`SCU_RX_FRM_BIT];
      rxOverrun      <= rxDrop | (rxOverrun & ~rxOverrunClear);
      serialIrq      <= topInterruptEnable & (|(evt & serialInterruptMask));
    end
  end

  assign rxErrorValidAB = rxErrVal_q;
  assign rxErrorOffsetA = rxErrOff_q[0];
  assign rxErrorOffsetB = rxErrOff_q[1];
endmodule

// ==== tb/scu_line_ctrl_chk.sv ====
/*
  Concurrent checks on the line controller's top ports.
  Bound from the testbench top; one clock, asynchronous active-low reset.
*/
`timescale 1ns/10ps
module scu_line_ctrl_chk (
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic [1:0] serialProtocolSelect,
  input wire logic       flowControlEnable,
  input wire logic       autoRequestToSend,
  input wire logic       softRequestToSend,
  input wire logic       fourWirePinMap,
  input wire logic       clearToSendN,
  input wire logic       rxOverrunClear,
  input wire logic [1:0] rxBufferLoad,
  input wire logic [1:0] dmaChannelReset,
  input wire logic [9:0] serialInterruptMask,
  input wire logic       topInterruptEnable,
  input wire logic       txdPin,
  input wire logic       requestToSendN,
  input wire logic       txAllSent,
  input wire logic       rxFifoNonempty,
  input wire logic       rxOverrun,
  input wire logic [1:0] rxErrorValidAB,
  input wire logic       serialIrq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  chk_reset_state: assert property ($rose(resetn) |-> txdPin && requestToSendN && txAllSent && !rxOverrun)
    else $error("outputs not at reset values");
  chk_mode_quiet: assert property ((serialProtocolSelect != 2'h1) [*2] |-> txdPin)
    else $error("line active outside line mode");
  chk_rts_manual: assert property ($past(serialProtocolSelect == 2'h1 && flowControlEnable && fourWirePinMap
    && !autoRequestToSend) |->
    requestToSendN == !$past(softRequestToSend)) else $error("manual request-to-send wrong");
  chk_rts_auto: assert property ((flowControlEnable && fourWirePinMap && autoRequestToSend && !rxFifoNonempty) [*3]
    |-> !requestToSendN) else $error("request-to-send off with empty buffer");
  chk_rts_full: assert property ($rose(rxOverrun) && flowControlEnable && fourWirePinMap && autoRequestToSend
    |-> requestToSendN) else $error("request-to-send on with full buffer");
  chk_cts_hold: assert property ($fell(txAllSent) && flowControlEnable && clearToSendN |-> txdPin [*3])
    else $error("character started without clear-to-send");
  chk_tx_start: assert property ($fell(txAllSent) && !flowControlEnable |-> ##[1:40] !txdPin)
    else $error("no start bit after write");
  chk_idle_line: assert property (txAllSent && $past(txAllSent) |-> txdPin)
    else $error("line low while all sent");
  chk_ovr_sticky: assert property (rxOverrun && !rxOverrunClear |=> rxOverrun)
    else $error("overrun flag lost");
  chk_irq_mask: assert property (!topInterruptEnable [*2] |-> !serialIrq)
    else $error("interrupt with top mask off");
  chk_irq_rxval: assert property ($rose(rxFifoNonempty) && serialInterruptMask[2] && topInterruptEnable
    |-> ##[0:2] serialIrq) else $error("no interrupt on receive valid");
  chk_mark_hold: assert property (rxErrorValidAB[0] && !dmaChannelReset[0] && !rxBufferLoad[0]
    |=> rxErrorValidAB[0]) else $error("error mark dropped");
endmodule

// ==== tb/scu_remote_term.sv ====
/*
  Remote serial terminal: sends frames on the receive line, decodes the transmit line.
  Bit time in ns is set by the bench; the line idles high.
*/
`timescale 1ns/10ps
module scu_remote_term (
  output logic       rxd,
  input  wire logic  txd,
  input  wire logic [3:0] nBits
);
  realtime    bitNs = 666.67;
  logic [8:0] got[$];
  logic [8:0] c;

  initial rxd = 1'b1;

  // Low start, data LSB first, optional parity, stop bit chosen by caller
  task automatic send(input logic [7:0] d, input logic parOn, input logic par, input logic stopBit);
    rxd = 1'b0;
    #bitNs;
    for (int i = 0; i < nBits; i++) begin
      rxd = d[i];
      #bitNs;
    end
    if (parOn) begin
      rxd = par;
      #bitNs;
    end
    rxd = stopBit;
    #bitNs;
    rxd = 1'b1;
    #(2 * bitNs);
  endtask

  // Mid-bit sampling; the bit after the data is kept as bit 8
  always begin
    @(negedge txd);
    #(1.5 * bitNs);
    c = 9'h000;
    for (int i = 0; i < nBits; i++) begin
      c[i] = txd;
      #bitNs;
    end
    c[8] = txd;
    got.push_back(c);
    wait (txd === 1'b1);
  end
endmodule

// ==== tb/tb_scu_line_ctrl.sv ====
/*
  Self-checking bench of the line controller with a remote terminal model.
  Assumes the checker and terminal model are compiled before this file.
*/
`timescale 1ns/10ps
module tb_scu_line_ctrl;
  logic clk_sys = 0, resetn = 0, baudPeriodHalfStep = 0, eightDataBits = 1, twoStopBits = 0, parityEnable = 0;
  logic oddParitySelect = 0, flowControlEnable = 0, autoRequestToSend = 0, softRequestToSend = 0, fourWirePinMap = 0;
  logic txWrite = 0, rxRead = 0, dmaRxRead = 0, rxOverrunClear = 0, topInterruptEnable = 1, clearToSendN = 0;
  logic [1:0]  serialProtocolSelect = 0, txBufferActiveAB = 0, rxBufferActiveAB = 0, rxBufferLoad = 0, dmaChannelReset = 0;
  logic [15:0] baudPeriodInteger = 16'h0008;
  logic [7:0]  txWriteData = 8'h00;
  logic [9:0]  serialInterruptMask = 10'h3ff;
  logic        rxdPin, txdPin, requestToSendN, txAllSent, txFifoHasSpace, rxFifoNonempty, rxParityError, rxFramingError;
  logic        rxOverrun, serialIrq;
  logic [1:0]  rxErrorValidAB;
  logic [7:0]  rxReadData;
  logic [15:0] rxErrorOffsetA, rxErrorOffsetB;
  logic [3:0]  nBits = 4'h8;
  logic [7:0]  sent[5];
  int          n_fail = 0, n_compared = 0;

  always #25 clk_sys = ~clk_sys;

  scu_line_ctrl dut (.*);
  scu_remote_term term (.rxd(rxdPin), .txd(txdPin), .nBits(nBits));

  function automatic logic par(logic [7:0] d, logic odd);
    return ^d ^ odd;
  endfunction

  task automatic check_flag(string what, logic e, logic g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic check_char(string what, logic [8:0] e, logic [8:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic write_tx(logic [7:0] d);
    @(posedge clk_sys);
    txWrite <= 1;
    txWriteData <= d;
    @(posedge clk_sys);
    txWrite <= 0;
    @(posedge clk_sys);
  endtask

  task automatic pop(logic dma);
    @(posedge clk_sys);
    rxRead <= !dma;
    dmaRxRead <= dma;
    @(posedge clk_sys);
    rxRead <= 0;
    dmaRxRead <= 0;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic wait_tx(int n);
    for (int k = 0; k < 4000 && !(txAllSent === 1'b1 && term.got.size() == n); k++) @(posedge clk_sys);
    check_char("tx count", 9'(n), 9'(term.got.size()));
  endtask

  task automatic give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Whole run is about 150 us
  initial begin
    #1ms;
    n_fail++;
    give_verdict;
  end

  initial begin
    void'($urandom(32'hc316));
    repeat (12) @(posedge clk_sys);
    resetn <= 1;
    repeat (3) @(posedge clk_sys);
    serialProtocolSelect <= 2'h1;
    flowControlEnable <= 1;
    fourWirePinMap <= 1;
    softRequestToSend <= 1;
    // Full buffer held back by clear-to-send, then drained
    for (int f = 0; f < 2; f++) begin
      eightDataBits <= !f[0];
      parityEnable <= f[0];
      oddParitySelect <= f[0];
      twoStopBits <= f[0];
      baudPeriodHalfStep <= f[0];
      nBits <= f[0] ? 4'h7 : 4'h8;
      term.bitNs = (f ? 17 : 16) * 1000.0 / 24;
      clearToSendN <= 1;
      for (int i = 0; i < 5; i++) begin
        sent[i] = $urandom;
        write_tx(sent[i]);
      end
      check_flag("space", 0, txFifoHasSpace);
      check_flag("all sent", 0, txAllSent);
      check_flag("line held", 1, txdPin);
      clearToSendN <= 0;
      wait_tx(4);
      check_flag("all sent", 1, txAllSent);
      check_flag("space", 1, txFifoHasSpace);
      for (int i = 0; i < 4; i++) begin
        check_char("tx char", f ? {par(sent[i] & 8'h7f, 1'b1), sent[i] & 8'h7f} : {1'b1, sent[i]}, term.got[i]);
      end
      term.got.delete();
    end
    // Receive overrun with errors, read by software then by DMA
    eightDataBits <= 1;
    oddParitySelect <= 0;
    twoStopBits <= 0;
    baudPeriodHalfStep <= 0;
    autoRequestToSend <= 1;
    nBits <= 4'h8;
    term.bitNs = 16000.0 / 24;
    for (int p = 0; p < 2; p++) begin
      rxBufferActiveAB <= {1'b0, p[0]};
      topInterruptEnable <= p[0];
      for (int i = 0; i < 5; i++) begin
        sent[i] = $urandom;
        term.send(sent[i], 1'b1, par(sent[i], 1'b0) ^ (i == 2), i != 1);
      end
      repeat (40) @(posedge clk_sys);
      check_flag("overrun", 1, rxOverrun);
      for (int i = 0; i < 4; i++) begin
        check_char("rx char", {1'b0, sent[i]}, {1'b0, rxReadData});
        check_flag("parity err", i == 2, rxParityError);
        check_flag("frame err", i == 1, rxFramingError);
        pop(p[0]);
      end
      check_flag("nonempty", 0, rxFifoNonempty);
      check_flag("dma mark", p[0], rxErrorValidAB[0]);
      check_char("dma offset", 9'(p), 9'(rxErrorOffsetA));
      @(posedge clk_sys);
      rxOverrunClear <= 1;
      dmaChannelReset <= 2'h1;
      @(posedge clk_sys);
      rxOverrunClear <= 0;
      dmaChannelReset <= 2'h0;
      repeat (2) @(posedge clk_sys);
      check_flag("mark cleared", 0, rxErrorValidAB[0]);
    end
    // Two-wire map without flow control
    flowControlEnable <= 0;
    fourWirePinMap <= 0;
    write_tx(8'ha5);
    wait_tx(1);
    check_char("tx char", {parityEnable ? par(8'ha5, 1'b0) : 1'b1, 8'ha5}, term.got[0]);
    give_verdict;
  end
endmodule

bind scu_line_ctrl scu_line_ctrl_chk chk (.*);
